// File: core/cecr_pkg.sv
// Shared constants and types of the consumer-control receive/reset slice
package cecr_pkg;

   // Register byte offsets
   localparam logic [7:0] CECR_OFS_MODULE_ENABLE = 8'h00;
   localparam logic [7:0] CECR_OFS_LOGICAL_ADDR = 8'h04;
   localparam logic [7:0] CECR_OFS_SOFT_RESET = 8'h08;
   localparam logic [7:0] CECR_OFS_RX_ENABLE = 8'h0c;
   localparam logic [7:0] CECR_OFS_RX_BUFFER = 8'h10;
   localparam logic [7:0] CECR_OFS_RX_CTRL_ONE = 8'h14;
   localparam logic [7:0] CECR_OFS_RX_CTRL_TWO = 8'h18;
   localparam logic [7:0] CECR_OFS_RX_CTRL_THREE = 8'h1c;
   localparam logic [7:0] CECR_OFS_IRQ_STATUS = 8'h40;
   localparam logic [7:0] CECR_OFS_IRQ_ENABLE = 8'h44;
   localparam logic [7:0] CECR_OFS_IRQ_CLEAR = 8'h48;

   // Field positions and widths
   localparam int CECR_BIT_MODULE_ENABLE = 0;
   localparam int CECR_BIT_SOFT_RESET = 0;
   localparam int CECR_BIT_RX_ENABLE = 0;
   localparam int CECR_MODULE_ENABLE_W = 3;
   localparam int CECR_LOGICAL_ADDR_W = 16;
   localparam int CECR_RX_CTRL_ONE_W = 25;
   localparam int CECR_RX_CTRL_TWO_W = 15;
   localparam int CECR_RX_CTRL_THREE_W = 24;
   localparam int CECR_IRQ_W = 2;
   localparam int CECR_IRQ_BYTE_DONE = 0;
   localparam int CECR_IRQ_OVERWRITE = 1;

   // Reset values
   localparam logic [31:0] CECR_RST_ZERO = 32'h0000_0000;
   localparam logic [2:0] CECR_RST_MODULE_ENABLE = 3'h0;

   // Counts of stages and bits
   localparam int CECR_RX_EN_STAGES = 2;
   localparam int CECR_DATA_BITS = 8;
   localparam int CECR_BLOCK_BITS = 10;
   localparam logic [3:0] CECR_LAST_BIT = 4'(CECR_BLOCK_BITS - 1);

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } cecr_apb_req_t;

   // One received block: ack at 9, eom at 8, data at 7..0
   typedef struct packed {
      logic ack;
      logic eom;
      logic [7:0] data;
   } cecr_rx_block_t;

endpackage

// File: core/cecr_en_delay.sv
// Delay chain that carries the receive enable to the receive circuit
`timescale 1ns/1ps
module cecr_en_delay #(
   parameter int STAGES = 2
) (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_reset_n,
   // Control
   input wire logic i_clr,
   input wire logic i_adv,
   input wire logic i_req,
   // Result
   output logic o_active
);
   logic [STAGES-1:0] stage_ff;

   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         stage_ff <= '0;
      end else if (i_clr) begin
         stage_ff <= '0;
      end else if (i_adv) begin
         stage_ff <= {stage_ff[STAGES-2:0], i_req};
      end
   end

   assign o_active = stage_ff[STAGES-1];
endmodule

// File: core/cecr_rx_shift.sv
// Assembles decoded line bits into one received block
`timescale 1ns/1ps
module cecr_rx_shift
   import cecr_pkg::*;
(
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_reset_n,
   // Control
   input wire logic i_clr,
   input wire logic i_run,
   // Decoded bits
   input wire logic i_bit_stb,
   input wire logic i_bit_val,
   // Result
   output logic o_done,
   output cecr_pkg::cecr_rx_block_t o_block
);
   logic [3:0] bit_cnt_ff;
   logic [CECR_BLOCK_BITS-1:0] shift_ff;
   logic done_ff;

   // Bits arrive data first (msb first), then eom, then ack
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         bit_cnt_ff <= '0;
         shift_ff <= '0;
         done_ff <= 1'b0;
      end else if (i_clr || !i_run) begin
         bit_cnt_ff <= '0;
         shift_ff <= '0;
         done_ff <= 1'b0;
      end else begin
         done_ff <= 1'b0;
         if (i_bit_stb) begin
            shift_ff <= {shift_ff[CECR_BLOCK_BITS-2:0], i_bit_val};
            if (bit_cnt_ff == CECR_LAST_BIT) begin
               bit_cnt_ff <= '0;
               done_ff <= 1'b1;
            end else begin
               bit_cnt_ff <= bit_cnt_ff + 4'h1;
            end
         end
      end
   end

   assign o_done = done_ff;
   assign o_block.data = shift_ff[CECR_BLOCK_BITS-1 -: CECR_DATA_BITS];
   assign o_block.eom = shift_ff[1];
   assign o_block.ack = shift_ff[0];
endmodule

// File: core/cecr_top.sv
// Receive control, soft reset and receive buffer with APB register access
//
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module cecr_top
   import cecr_pkg::*;
(
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_reset_n,
   // APB slave
   input cecr_pkg::cecr_apb_req_t i_apb,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // Decoded bits from the line timing front end
   input wire logic i_rx_bit_stb,
   input wire logic i_rx_bit_val,
   // Drive request from the transmitter
   input wire logic i_tx_drive_low,
   // Bus line (open drain: output always low, enable pulls the line)
   output logic o_line_out,
   output logic o_line_oe,
   // To the rest of the unit
   output logic o_unit_soft_reset,
   output logic o_module_enable,
   output logic [CECR_RX_CTRL_ONE_W-1:0] o_rx_ctrl_one,
   output logic [CECR_RX_CTRL_TWO_W-1:0] o_rx_ctrl_two,
   output logic [CECR_RX_CTRL_THREE_W-1:0] o_rx_ctrl_three,
   output logic [CECR_LOGICAL_ADDR_W-1:0] o_logical_addr,
   output logic o_rx_active,
   output logic o_irq
);
   logic [2:0] module_enable_ff;
   logic [CECR_LOGICAL_ADDR_W-1:0] logical_addr_ff;
   logic [CECR_RX_CTRL_ONE_W-1:0] rx_ctrl_one_ff;
   logic [CECR_RX_CTRL_TWO_W-1:0] rx_ctrl_two_ff;
   logic [CECR_RX_CTRL_THREE_W-1:0] rx_ctrl_three_ff;
   logic rx_enable_req_ff;
   cecr_rx_block_t rx_buffer_ff;
   logic [CECR_IRQ_W-1:0] irq_status_ff;
   logic [CECR_IRQ_W-1:0] irq_enable_ff;
   logic irq_ff;
   logic pready_ff;
   logic pslverr_ff;
   logic [31:0] prdata_ff;
   logic line_oe_ff;
   logic unit_srst_ff;
   logic rx_active_ff;

   logic clk_en;
   logic access;
   logic commit_wr;
   logic soft_rst;
   logic rx_active;
   logic rx_done;
   cecr_rx_block_t rx_block;
   logic [CECR_IRQ_W-1:0] irq_set;
   logic [CECR_IRQ_W-1:0] irq_clr;
   logic [31:0] nxt_prdata;
   logic nxt_slverr;

   // Everything but the enable register and the APB answer is frozen while the unit is off; the bit assembler is cleared
   assign clk_en = module_enable_ff[CECR_BIT_MODULE_ENABLE];

   assign access = i_apb.psel && i_apb.penable;
   // A write takes effect at the edge where pready is sampled high
   assign commit_wr = access && pready_ff && i_apb.pwrite;

   // One-shot: exists only in the cycle of the committing write
   assign soft_rst = clk_en && commit_wr && (i_apb.paddr == CECR_OFS_SOFT_RESET)
                     && i_apb.pwdata[CECR_BIT_SOFT_RESET];

   // APB handshake: one wait state, answer registered
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         pready_ff <= 1'b0;
      end else begin
         pready_ff <= access && !pready_ff;
      end
   end

   always_comb begin
      nxt_prdata = CECR_RST_ZERO;
      nxt_slverr = 1'b0;
      case (i_apb.paddr)
         CECR_OFS_MODULE_ENABLE: nxt_prdata[2:0] = module_enable_ff;
         CECR_OFS_LOGICAL_ADDR: nxt_prdata[CECR_LOGICAL_ADDR_W-1:0] = logical_addr_ff;
         // Write-only trigger reads zero
         CECR_OFS_SOFT_RESET: nxt_prdata = CECR_RST_ZERO;
         // Reads back the receive circuit, not the written request
         CECR_OFS_RX_ENABLE: nxt_prdata[CECR_BIT_RX_ENABLE] = rx_active;
         CECR_OFS_RX_BUFFER: nxt_prdata[CECR_BLOCK_BITS-1:0] = rx_buffer_ff;
         CECR_OFS_RX_CTRL_ONE: nxt_prdata[CECR_RX_CTRL_ONE_W-1:0] = rx_ctrl_one_ff;
         CECR_OFS_RX_CTRL_TWO: nxt_prdata[CECR_RX_CTRL_TWO_W-1:0] = rx_ctrl_two_ff;
         CECR_OFS_RX_CTRL_THREE: nxt_prdata[CECR_RX_CTRL_THREE_W-1:0] = rx_ctrl_three_ff;
         CECR_OFS_IRQ_STATUS: nxt_prdata[CECR_IRQ_W-1:0] = irq_status_ff;
         CECR_OFS_IRQ_ENABLE: nxt_prdata[CECR_IRQ_W-1:0] = irq_enable_ff;
         CECR_OFS_IRQ_CLEAR: nxt_prdata = CECR_RST_ZERO;
         default: nxt_slverr = 1'b1;
      endcase
   end

   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         prdata_ff <= CECR_RST_ZERO;
         pslverr_ff <= 1'b0;
      end else if (access && !pready_ff) begin
         prdata_ff <= i_apb.pwrite ? CECR_RST_ZERO : nxt_prdata;
         pslverr_ff <= nxt_slverr;
      end else begin
         prdata_ff <= CECR_RST_ZERO;
         pslverr_ff <= 1'b0;
      end
   end

   // Enable register: clocked always and untouched by soft reset
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         module_enable_ff <= CECR_RST_MODULE_ENABLE;
      end else if (commit_wr && i_apb.paddr == CECR_OFS_MODULE_ENABLE) begin
         module_enable_ff <= i_apb.pwdata[2:0];
      end
   end

   // Settings registers
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         logical_addr_ff <= '0;
         rx_ctrl_one_ff <= '0;
         rx_ctrl_two_ff <= '0;
         rx_ctrl_three_ff <= '0;
         irq_enable_ff <= '0;
      end else if (soft_rst) begin
         logical_addr_ff <= '0;
         rx_ctrl_one_ff <= '0;
         rx_ctrl_two_ff <= '0;
         rx_ctrl_three_ff <= '0;
         irq_enable_ff <= '0;
      end else if (clk_en && commit_wr) begin
         case (i_apb.paddr)
            CECR_OFS_LOGICAL_ADDR: logical_addr_ff <= i_apb.pwdata[CECR_LOGICAL_ADDR_W-1:0];
            // Written before the receiver is armed; not guarded here
            CECR_OFS_RX_CTRL_ONE: rx_ctrl_one_ff <= i_apb.pwdata[CECR_RX_CTRL_ONE_W-1:0];
            CECR_OFS_RX_CTRL_TWO: rx_ctrl_two_ff <= i_apb.pwdata[CECR_RX_CTRL_TWO_W-1:0];
            CECR_OFS_RX_CTRL_THREE: rx_ctrl_three_ff <= i_apb.pwdata[CECR_RX_CTRL_THREE_W-1:0];
            CECR_OFS_IRQ_ENABLE: irq_enable_ff <= i_apb.pwdata[CECR_IRQ_W-1:0];
            default: ;
         endcase
      end
   end

   // Receive enable request
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rx_enable_req_ff <= 1'b0;
      end else if (soft_rst) begin
         rx_enable_req_ff <= 1'b0;
      end else if (clk_en && commit_wr && i_apb.paddr == CECR_OFS_RX_ENABLE) begin
         rx_enable_req_ff <= i_apb.pwdata[CECR_BIT_RX_ENABLE];
      end
   end

   // The request needs a few cycles to reach the receive circuit
   cecr_en_delay #(
      .STAGES(CECR_RX_EN_STAGES)
   ) u_en_delay (
      .i_ref_clk(i_ref_clk),
      .i_reset_n(i_reset_n),
      .i_clr(soft_rst),
      .i_adv(clk_en),
      .i_req(rx_enable_req_ff),
      .o_active(rx_active)
   );

   cecr_rx_shift u_rx_shift (
      .i_ref_clk(i_ref_clk),
      .i_reset_n(i_reset_n),
      .i_clr(soft_rst),
      .i_run(clk_en && rx_active),
      .i_bit_stb(i_rx_bit_stb),
      .i_bit_val(i_rx_bit_val),
      .o_done(rx_done),
      .o_block(rx_block)
   );

   // Buffer is loaded only by the receiver; bus writes never reach it
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rx_buffer_ff <= '0;
      end else if (soft_rst) begin
         rx_buffer_ff <= '0;
      end else if (clk_en && rx_done) begin
         rx_buffer_ff <= rx_block;
      end
   end

   // Sticky events; a set in the clearing cycle wins
   assign irq_set[CECR_IRQ_BYTE_DONE] = clk_en && rx_done;
   assign irq_set[CECR_IRQ_OVERWRITE] = clk_en && rx_done && irq_status_ff[CECR_IRQ_BYTE_DONE];
   assign irq_clr = (clk_en && commit_wr && i_apb.paddr == CECR_OFS_IRQ_CLEAR) ?
                    i_apb.pwdata[CECR_IRQ_W-1:0] : '0;

   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         irq_status_ff <= '0;
         irq_ff <= 1'b0;
      end else if (soft_rst) begin
         irq_status_ff <= '0;
         irq_ff <= 1'b0;
      end else if (clk_en) begin
         irq_status_ff <= (irq_status_ff & ~irq_clr) | irq_set;
         irq_ff <= |(((irq_status_ff & ~irq_clr) | irq_set) & irq_enable_ff);
      end
   end

   // Line drive: dropped in the reset cycle and held off while the
   // transmitter is being reset, so no partial bit is finished
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         line_oe_ff <= 1'b0;
         unit_srst_ff <= 1'b0;
      end else begin
         unit_srst_ff <= soft_rst;
         if (soft_rst || unit_srst_ff) begin
            line_oe_ff <= 1'b0;
         end else if (clk_en) begin
            line_oe_ff <= i_tx_drive_low;
         end
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rx_active_ff <= 1'b0;
      end else begin
         rx_active_ff <= rx_active;
      end
   end

   assign o_prdata = prdata_ff;
   assign o_pready = pready_ff;
   assign o_pslverr = pslverr_ff;
   assign o_line_out = 1'b0;
   assign o_line_oe = line_oe_ff;
   assign o_unit_soft_reset = unit_srst_ff;
   assign o_module_enable = module_enable_ff[CECR_BIT_MODULE_ENABLE];
   assign o_rx_ctrl_one = rx_ctrl_one_ff;
   assign o_rx_ctrl_two = rx_ctrl_two_ff;
   assign o_rx_ctrl_three = rx_ctrl_three_ff;
   assign o_logical_addr = logical_addr_ff;
   assign o_rx_active = rx_active_ff;
   assign o_irq = irq_ff;
endmodule

// File: sim/cecr_assertions.sv
// Port-level concurrent checks of the receive control slice
`timescale 1ns/1ps
module cecr_assertions
   import cecr_pkg::*;
(
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_reset_n,
   // Register bus
   input cecr_pkg::cecr_apb_req_t i_apb,
   input wire logic [31:0] o_prdata,
   input wire logic o_pready,
   // Unit side
   input wire logic i_tx_drive_low,
   input wire logic o_line_out,
   input wire logic o_line_oe,
   input wire logic o_unit_soft_reset,
   input wire logic o_module_enable,
   input wire logic [CECR_RX_CTRL_ONE_W-1:0] o_rx_ctrl_one,
   input wire logic [CECR_RX_CTRL_TWO_W-1:0] o_rx_ctrl_two,
   input wire logic [CECR_LOGICAL_ADDR_W-1:0] o_logical_addr,
   input wire logic o_rx_active,
   input wire logic o_irq
);
   import cecr_pkg::*;
   logic xfer;
   logic wr;
   assign xfer = i_apb.psel & i_apb.penable & o_pready;
   assign wr = xfer & i_apb.pwrite;
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_reset_n);
   AST_LINE_LOW: assert property (o_line_oe |-> o_line_out == 1'b0)
      else $error("line not pulled low");
   AST_LINE_FOLLOW: assert property (o_module_enable && !o_unit_soft_reset
      && !(wr && i_apb.paddr == 8'h08) |=> o_line_oe == $past(i_tx_drive_low))
      else $error("line drive does not follow the transmitter");
   AST_SRST_PULSE: assert property (o_unit_soft_reset |=> !o_unit_soft_reset)
      else $error("soft reset pulse too long");
   AST_SRST_LINE: assert property (o_unit_soft_reset |-> !o_line_oe)
      else $error("line still driven at soft reset");
   AST_SRST_CLEAR: assert property (o_unit_soft_reset |-> o_rx_ctrl_one == '0
      && o_rx_ctrl_two == '0 && o_logical_addr == '0 && o_module_enable)
      else $error("registers not cleared by soft reset");
   AST_SRST_STOP: assert property (o_unit_soft_reset |=> !o_rx_active && !o_irq)
      else $error("receiver still active after soft reset");
   AST_RD_ZERO: assert property (xfer && !i_apb.pwrite && i_apb.paddr == 8'h08
      |-> o_prdata == 32'h0)
      else $error("soft reset register not read as zero");
   AST_BUF_UPPER: assert property (xfer && !i_apb.pwrite && i_apb.paddr == 8'h10
      |-> o_prdata[31:10] == '0)
      else $error("buffer upper bits not zero");
   AST_MOD_HOLD: assert property (!o_module_enable && !(wr && i_apb.paddr == 8'h00)
      |=> $stable(o_rx_ctrl_one) && $stable(o_rx_ctrl_two) && $stable(o_logical_addr))
      else $error("settings changed while disabled");
   AST_RX_ON: assert property (wr && i_apb.paddr == 8'h0c && i_apb.pwdata[0]
      && o_module_enable |-> ##[1:6] o_rx_active)
      else $error("receiver not armed");
   AST_RX_OFF: assert property (wr && i_apb.paddr == 8'h0c && !i_apb.pwdata[0]
      && o_module_enable |-> ##[1:6] !o_rx_active)
      else $error("receiver not stopped");
endmodule

bind cecr_top cecr_assertions u_chk (.i_ref_clk, .i_reset_n, .i_apb, .o_prdata, .o_pready,
   .o_line_out, .o_line_oe, .o_unit_soft_reset, .o_module_enable, .o_rx_ctrl_one,
   .o_rx_ctrl_two, .o_logical_addr, .o_rx_active, .o_irq, .i_tx_drive_low);

// File: sim/cecr_line_partner.sv
// Far-side equipment that sends decoded blocks bit by bit
`timescale 1ns/1ps
module cecr_line_partner (
   // Clock
   input wire logic i_ref_clk,
   // Decoded bits
   output logic o_bit_stb,
   output logic o_bit_val
);
   initial begin
      o_bit_stb = 1'b0;
      o_bit_val = 1'b0;
   end
   // Data msb first, then end-of-message, then acknowledge
   task automatic send_block(input logic [9:0] blk, input int gap);
      for (int i = 9; i >= 0; i--) begin
         @(posedge i_ref_clk);
         o_bit_stb <= 1'b1;
         o_bit_val <= blk[i];
         @(posedge i_ref_clk);
         o_bit_stb <= 1'b0;
         // Value inverted between strobes so a stale level is never mistaken for data
         o_bit_val <= ~blk[i];
         repeat (gap) @(posedge i_ref_clk);
      end
   endtask
endmodule

// File: sim/test_cec_reset_rx_control.sv
// Self-checking bench of the receive control slice
`timescale 1ns/1ps
module test_cec_reset_rx_control;
   import cecr_pkg::*;
   logic i_ref_clk = 1'b0;
   logic i_reset_n = 1'b0;
   cecr_apb_req_t i_apb = '0;
   logic i_tx_drive_low = 1'b0;
   logic [31:0] o_prdata;
   logic o_pready, o_pslverr, i_rx_bit_stb, i_rx_bit_val, o_line_out, o_line_oe;
   logic o_unit_soft_reset, o_module_enable, o_rx_active, o_irq;
   logic [CECR_RX_CTRL_ONE_W-1:0] o_rx_ctrl_one;
   logic [CECR_RX_CTRL_TWO_W-1:0] o_rx_ctrl_two;
   logic [CECR_RX_CTRL_THREE_W-1:0] o_rx_ctrl_three;
   logic [CECR_LOGICAL_ADDR_W-1:0] o_logical_addr;
   int n_fail = 0;
   int comparisons = 0;
   int mdl[int];
   logic [31:0] q;
   logic e;
   logic [7:0] regs[10] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h40, 8'h44};
   logic [7:0] cfg[4] = '{8'h04, 8'h14, 8'h18, 8'h1c};

   always #5 i_ref_clk = ~i_ref_clk;

   cecr_top uut (.i_ref_clk, .i_reset_n, .i_apb, .o_prdata, .o_pready, .o_pslverr,
      .i_rx_bit_stb, .i_rx_bit_val, .i_tx_drive_low, .o_line_out, .o_line_oe,
      .o_unit_soft_reset, .o_module_enable, .o_rx_ctrl_one, .o_rx_ctrl_two,
      .o_rx_ctrl_three, .o_logical_addr, .o_rx_active, .o_irq);
   cecr_line_partner far (.i_ref_clk, .o_bit_stb(i_rx_bit_stb), .o_bit_val(i_rx_bit_val));

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
      comparisons++;
      if (g !== x) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", n, x, g);
      end
   endtask
   function automatic logic [31:0] mv(input int a);
      return mdl.exists(a) ? 32'(mdl[a]) : 32'h0;
   endfunction
   function automatic int mask(input logic [7:0] a);
      case (a)
         8'h04: return 32'hffff;
         8'h14: return 32'h1ff_ffff;
         8'h18: return 32'h7fff;
         8'h1c: return 32'hff_ffff;
         8'h44: return 3;
         default: return 0;
      endcase
   endfunction
   // Request held until pready is sampled high at a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int t;
      t = 0;
      @(posedge i_ref_clk);
      i_apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
      @(posedge i_ref_clk);
      i_apb.penable <= 1'b1;
      do begin
         @(posedge i_ref_clk);
         t++;
      end while (o_pready !== 1'b1 && t < 50);
      if (t >= 50) n_fail++;
      q = o_prdata;
      e = o_pslverr;
      i_apb <= '0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
      if (a == 8'h00) mdl[0] = d & 7;
      else if ((mv(0) & 1) && a == 8'h08 && d[0]) begin
         for (int k = 4; k < 80; k += 4) mdl[k] = 0;
      end else if ((mv(0) & 1) && a == 8'h48) mdl[64] = mv(64) & ~d;
      // Read-only and unmapped words keep their contents
      else if ((mv(0) & 1) && mask(a) != 0) mdl[a] = d & mask(a);
   endtask
   task automatic outchk();
      chk("module enable", mv(0) & 1, {31'h0, o_module_enable});
      chk("logical address", mv(4), 32'(o_logical_addr));
      chk("receive control one", mv(20), 32'(o_rx_ctrl_one));
      chk("receive control two", mv(24), 32'(o_rx_ctrl_two));
      chk("receive control three", mv(28), 32'(o_rx_ctrl_three));
      chk("receive active output", mv(12), {31'h0, o_rx_active});
   endtask
   task automatic rdchk(input logic [7:0] a);
      apb(1'b0, a, 32'h0);
      chk($sformatf("register %h", a), mv(a), q);
   endtask
   task automatic wait_rx(input logic v);
      for (int k = 0; k < 20; k++) begin
         apb(1'b0, 8'h0c, 32'h0);
         if (q[0] === v) break;
      end
      chk("receive state", {31'h0, v}, q);
      chk("receive active output", {31'h0, v}, {31'h0, o_rx_active});
      mdl[12] = v;
   endtask
   task automatic rx_block(input logic [9:0] blk, input logic on);
      far.send_block(blk, $urandom_range(0, 2));
      repeat (4) @(posedge i_ref_clk);
      if (on) begin
         mdl[16] = {blk[0], blk[1], blk[9:2]};
         mdl[64] = mv(64) | 1 | ((mv(64) & 1) << 1);
      end
      chk("irq", {31'h0, (mv(64) & mv(68)) != 0}, {31'h0, o_irq});
   endtask

   initial begin
      repeat (20000) @(posedge i_ref_clk);
      n_fail++;
      close_out();
   end

   initial begin
      void'($urandom(32'hd19d));
      repeat (16) @(posedge i_ref_clk);
      i_reset_n <= 1'b1;
      foreach (regs[i]) rdchk(regs[i]);
      apb(1'b0, 8'h80, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, e});
      $display("test reset values finished");
      foreach (cfg[i]) wr(cfg[i], $urandom());
      foreach (cfg[i]) rdchk(cfg[i]);
      outchk();
      wr(8'h00, 32'h3);
      foreach (cfg[i]) wr(cfg[i], $urandom());
      foreach (cfg[i]) rdchk(cfg[i]);
      outchk();
      wr(8'h00, 32'h2);
      foreach (cfg[i]) wr(cfg[i], $urandom());
      foreach (cfg[i]) rdchk(cfg[i]);
      outchk();
      wr(8'h00, 32'h3);
      $display("test settings finished");
      rx_block(10'($urandom()), 1'b0);
      rdchk(8'h10);
      rdchk(8'h0c);
      wr(8'h0c, 32'h1);
      wait_rx(1'b1);
      wr(8'h44, 32'h1);
      repeat (4) begin
         rx_block(10'($urandom()), 1'b1);
         rdchk(8'h10);
         rdchk(8'h40);
      end
      wr(8'h10, 32'hffff_ffff);
      rdchk(8'h10);
      wr(8'h44, 32'h0);
      // The enable lands at the committing edge, the registered output one edge later
      repeat (2) @(posedge i_ref_clk);
      chk("irq masked", 32'h0, {31'h0, o_irq});
      wr(8'h44, 32'h3);
      wr(8'h48, 32'h3);
      rdchk(8'h40);
      chk("irq cleared", 32'h0, {31'h0, o_irq});
      wr(8'h0c, 32'h0);
      wait_rx(1'b0);
      rx_block(10'($urandom()), 1'b0);
      rdchk(8'h10);
      $display("test receive finished");
      wr(8'h0c, 32'h1);
      wait_rx(1'b1);
      i_tx_drive_low <= 1'b1;
      repeat (3) @(posedge i_ref_clk);
      chk("line drive", 32'h1, {31'h0, o_line_oe});
      chk("line level", 32'h0, {31'h0, o_line_out});
      fork
         far.send_block(10'($urandom()), 2);
         begin
            repeat (12) @(posedge i_ref_clk);
            wr(8'h08, 32'h1);
            @(posedge i_ref_clk);
            chk("soft reset pulse", 32'h1, {31'h0, o_unit_soft_reset});
            chk("line dropped", 32'h0, {31'h0, o_line_oe});
         end
      join
      i_tx_drive_low <= 1'b0;
      repeat (3) @(posedge i_ref_clk);
      chk("line released", 32'h0, {31'h0, o_line_oe});
      foreach (regs[i]) rdchk(regs[i]);
      outchk();
      chk("irq after soft reset", 32'h0, {31'h0, o_irq});
      $display("test soft reset finished");
      close_out();
   end
endmodule
